// File: shared/hpvol_pkg.sv
// Purpose: Constants for the headphone gain control register bank
// Assumes: Register index 0x1C left, 0x1D right; 16-bit register data
// Notes: Gain code 0 is -57 dB, one dB per code
package hpvol_pkg;
    localparam logic [6:0] HPVOL_ADDR_LEFT = 7'h1C;
    localparam logic [6:0] HPVOL_ADDR_RIGHT = 7'h1D;
    localparam int HPVOL_BIT_COMMIT = 8;
    localparam int HPVOL_BIT_ZC = 7;
    localparam int HPVOL_BIT_SILENCE = 6;
    localparam int HPVOL_GAIN_W = 6;
    localparam logic [5:0] HPVOL_GAIN_RESET = 6'h2D;
    localparam logic [5:0] HPVOL_GAIN_0DB = 6'h39;
    localparam logic [5:0] HPVOL_GAIN_MAX = 6'h3F;
    localparam logic HPVOL_ZC_RESET = 1'b0;
    localparam logic HPVOL_SILENCE_RESET = 1'b0;
    // Zero-cross arming needs this many gain or silence changes
    localparam logic [1:0] HPVOL_ARM_WRITES = 2'h2;
    localparam int HPVOL_TIMEOUT_W = 4;
    localparam logic [3:0] HPVOL_TIMEOUT_TICKS = 4'h4;
endpackage

// File: hw/hpvol_ctrl.sv
// Purpose: Left/right headphone gain registers with pending/commit and zero-cross apply
// Assumes: One write port, single-cycle writes; zero-cross and timeout ticks are pulses
// Notes: A deferred apply takes the pending value at the crossing or timeout
`timescale 1ns/1ns
module hpvol_ctrl
    import hpvol_pkg::*;
#(
    parameter logic [3:0] TIMEOUT_TICKS = HPVOL_TIMEOUT_TICKS
) (
    input wire logic CLK, // 10 MHz clock
    input wire logic RESET_N, // Async reset, active low
    input wire logic WR_EN, // Register write strobe
    input wire logic [6:0] ADDR, // Register index
    input wire logic [15:0] WDATA, // Write data
    output logic [15:0] RDATA, // Read data for ADDR
    input wire logic [1:0] ZERO_CROSS, // Per channel zero-crossing pulse, [0] left
    input wire logic TIMEOUT_TICK, // Zero-cross timeout clock tick pulse
    output logic [5:0] LEFT_APPLIED_GAIN, // Gain code in effect, left
    output logic [5:0] RIGHT_APPLIED_GAIN, // Gain code in effect, right
    output logic LEFT_SILENCE_OUT, // Left output muted
    output logic RIGHT_SILENCE_OUT, // Right output muted
    output logic [1:0] APPLY_WAITING // Deferred apply outstanding per channel
);
    import hpvol_pkg::*;

    typedef struct packed {
        logic [5:0] pend_gain;
        logic pend_sil;
        logic zc_en;
        logic [5:0] app_gain;
        logic app_sil;
        logic [1:0] arm_cnt;
        logic waiting;
        logic [3:0] tmo;
    } hpvol_chan_t;

    typedef struct packed {
        hpvol_chan_t [1:0] ch;
    } hpvol_state_t;

    hpvol_state_t state_q, state_d;
    logic commit;
    logic [1:0] wr_ch;

    // commit is a strobe from either register
    assign commit = WR_EN && WDATA[HPVOL_BIT_COMMIT] &&
        (ADDR == HPVOL_ADDR_LEFT || ADDR == HPVOL_ADDR_RIGHT);
    assign wr_ch[0] = WR_EN && ADDR == HPVOL_ADDR_LEFT;
    assign wr_ch[1] = WR_EN && ADDR == HPVOL_ADDR_RIGHT;

    always_comb begin
        state_d = state_q;
        for (int i = 0; i < 2; i++) begin
            if (state_q.ch[i].waiting && TIMEOUT_TICK) begin
                state_d.ch[i].tmo = state_q.ch[i].tmo + 4'h1;
            end
            if (state_q.ch[i].waiting && (ZERO_CROSS[i] ||
                (TIMEOUT_TICK && state_q.ch[i].tmo + 4'h1 >= TIMEOUT_TICKS))) begin
                state_d.ch[i].app_gain = state_q.ch[i].pend_gain;
                state_d.ch[i].app_sil = state_q.ch[i].pend_sil;
                state_d.ch[i].waiting = 1'b0;
                state_d.ch[i].tmo = 4'h0;
            end
            if (wr_ch[i]) begin
                state_d.ch[i].pend_gain = WDATA[HPVOL_GAIN_W-1:0];
                state_d.ch[i].pend_sil = WDATA[HPVOL_BIT_SILENCE];
                state_d.ch[i].zc_en = WDATA[HPVOL_BIT_ZC];
                if (!WDATA[HPVOL_BIT_ZC]) begin
                    state_d.ch[i].arm_cnt = 2'h0;
                end else if (state_q.ch[i].zc_en &&
                    state_q.ch[i].arm_cnt != HPVOL_ARM_WRITES &&
                    (WDATA[HPVOL_GAIN_W-1:0] != state_q.ch[i].pend_gain ||
                     WDATA[HPVOL_BIT_SILENCE] != state_q.ch[i].pend_sil)) begin
                    state_d.ch[i].arm_cnt = state_q.ch[i].arm_cnt + 2'h1;
                end
            end
        end
        if (commit) begin
            for (int i = 0; i < 2; i++) begin
                if (state_d.ch[i].zc_en && state_d.ch[i].arm_cnt == HPVOL_ARM_WRITES) begin
                    state_d.ch[i].waiting = 1'b1;
                    state_d.ch[i].tmo = 4'h0;
                end else begin
                    state_d.ch[i].app_gain = state_d.ch[i].pend_gain;
                    state_d.ch[i].app_sil = state_d.ch[i].pend_sil;
                    state_d.ch[i].waiting = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < 2; i++) begin
                state_q.ch[i].pend_gain <= HPVOL_GAIN_RESET;
                state_q.ch[i].app_gain <= HPVOL_GAIN_RESET;
                state_q.ch[i].pend_sil <= HPVOL_SILENCE_RESET;
                state_q.ch[i].app_sil <= HPVOL_SILENCE_RESET;
                state_q.ch[i].zc_en <= HPVOL_ZC_RESET;
                state_q.ch[i].arm_cnt <= 2'h0;
                state_q.ch[i].waiting <= 1'b0;
                state_q.ch[i].tmo <= 4'h0;
            end
        end else begin
            state_q <= state_d;
        end
    end

    always_comb begin
        RDATA = 16'h0000;
        for (int i = 0; i < 2; i++) begin
            if (ADDR == (i == 0 ? HPVOL_ADDR_LEFT : HPVOL_ADDR_RIGHT)) begin
                RDATA = {8'h00, state_q.ch[i].zc_en, state_q.ch[i].pend_sil,
                    state_q.ch[i].pend_gain};
            end
        end
    end

    assign LEFT_APPLIED_GAIN = state_q.ch[0].app_gain;
    assign RIGHT_APPLIED_GAIN = state_q.ch[1].app_gain;
    assign LEFT_SILENCE_OUT = state_q.ch[0].app_sil;
    assign RIGHT_SILENCE_OUT = state_q.ch[1].app_sil;
    assign APPLY_WAITING = {state_q.ch[1].waiting, state_q.ch[0].waiting};

    AST_NO_COMMIT_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N)
        (wr_ch[0] && !commit && !state_q.ch[0].waiting) |=> $stable(LEFT_APPLIED_GAIN))
        else $error("left gain changed without commit");
    AST_OTHER_ADDR: assert property (@(posedge CLK) disable iff (!RESET_N)
        (WR_EN && !wr_ch[0] && !wr_ch[1] && APPLY_WAITING == 2'h0)
        |=> $stable(LEFT_APPLIED_GAIN) && $stable(RIGHT_APPLIED_GAIN))
        else $error("write to another address changed a gain");
    AST_COMMIT_BOTH: assert property (@(posedge CLK) disable iff (!RESET_N)
        (commit && wr_ch[0] && !WDATA[HPVOL_BIT_ZC] && !state_q.ch[1].zc_en)
        |=> RIGHT_APPLIED_GAIN == state_q.ch[1].pend_gain)
        else $error("right gain not committed");
    AST_IMMEDIATE: assert property (@(posedge CLK) disable iff (!RESET_N)
        (commit && wr_ch[0] && !WDATA[HPVOL_BIT_ZC])
        |=> LEFT_APPLIED_GAIN == $past(WDATA[5:0]))
        else $error("immediate apply missed");
    AST_SILENCE: assert property (@(posedge CLK) disable iff (!RESET_N)
        (commit && wr_ch[1] && !WDATA[HPVOL_BIT_ZC])
        |=> RIGHT_SILENCE_OUT == $past(WDATA[6]))
        else $error("silence not applied");
    AST_SILENCE_LEFT: assert property (@(posedge CLK) disable iff (!RESET_N)
        (commit && wr_ch[0] && !WDATA[HPVOL_BIT_ZC])
        |=> LEFT_SILENCE_OUT == $past(WDATA[6]))
        else $error("left silence not applied");
    AST_ARM: assert property (@(posedge CLK) disable iff (!RESET_N)
        (commit && state_q.ch[0].arm_cnt == 2'h0 && !wr_ch[0]) |=> !APPLY_WAITING[0])
        else $error("deferred before arming");
    // Deferral in steps: an armed commit, then the old gain holds while waiting
    sequence s_left_armed_commit;
        commit && wr_ch[0] && WDATA[HPVOL_BIT_ZC] && state_q.ch[0].zc_en &&
            state_q.ch[0].arm_cnt == HPVOL_ARM_WRITES;
    endsequence
    sequence s_right_armed_commit;
        commit && wr_ch[1] && WDATA[HPVOL_BIT_ZC] && state_q.ch[1].zc_en &&
            state_q.ch[1].arm_cnt == HPVOL_ARM_WRITES;
    endsequence
    sequence s_left_gain_held;
        APPLY_WAITING[0] && $stable(LEFT_APPLIED_GAIN);
    endsequence
    sequence s_right_gain_held;
        APPLY_WAITING[1] && $stable(RIGHT_APPLIED_GAIN);
    endsequence
    AST_LEFT_DEFER: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_left_armed_commit |=> s_left_gain_held)
        else $error("armed left commit not deferred");
    AST_RIGHT_DEFER: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_right_armed_commit |=> s_right_gain_held)
        else $error("armed right commit not deferred");
    sequence s_left_wait_on;
        APPLY_WAITING[0] && !ZERO_CROSS[0] && !commit &&
            !(TIMEOUT_TICK && state_q.ch[0].tmo + 4'h1 >= TIMEOUT_TICKS);
    endsequence
    AST_TIMEOUT_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_left_wait_on |=> s_left_gain_held)
        else $error("deferred gain applied early");
    AST_TIMEOUT: assert property (@(posedge CLK) disable iff (!RESET_N)
        (APPLY_WAITING[0] && TIMEOUT_TICK && !commit &&
            state_q.ch[0].tmo + 4'h1 >= TIMEOUT_TICKS)
        |=> !APPLY_WAITING[0])
        else $error("timeout did not apply");
    AST_READ_ZERO: assert property (@(posedge CLK) disable iff (!RESET_N) RDATA[15:8] == 8'h00)
        else $error("upper bits not zero");
    AST_ZC_APPLY: assert property (@(posedge CLK) disable iff (!RESET_N)
        (APPLY_WAITING[1] && ZERO_CROSS[1] && !commit) |=> !APPLY_WAITING[1])
        else $error("crossing did not apply");
    AST_ZC_APPLY_LEFT: assert property (@(posedge CLK) disable iff (!RESET_N)
        (APPLY_WAITING[0] && ZERO_CROSS[0] && !commit)
        |=> LEFT_APPLIED_GAIN == $past(state_q.ch[0].pend_gain) && !APPLY_WAITING[0])
        else $error("left crossing did not apply");
endmodule // hpvol_ctrl

// File: bench/hpvol_host.sv
// Purpose: Host model writing the headphone gain registers
// Assumes: Lines change just after a rising edge, one idle cycle between writes
// Notes: Released write data is inverted so a stale value is never trusted
`timescale 1ns/1ns
module hpvol_host (
    input wire logic CLK, // Bench clock
    output logic WR_EN, // Write strobe
    output logic [6:0] ADDR, // Register index
    output logic [15:0] WDATA // Write data
);
    initial begin
        WR_EN = 1'b0;
        ADDR = 7'h00;
        WDATA = 16'h0000;
    end
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge CLK);
        WR_EN <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR_EN <= 1'b0;
        WDATA <= ~d;
    endtask
    task automatic rd(input logic [6:0] a);
        @(posedge CLK);
        ADDR <= a;
    endtask
endmodule // hpvol_host

// File: bench/tb_top.sv
// Purpose: Self-checking bench for the headphone gain register bank
// Assumes: Timeout shortened to three ticks
// Notes: Model holds pending, applied and arming state per channel
`timescale 1ns/1ns
module tb_top;
    import hpvol_pkg::*;
    logic clk, reset_n, wr_en, tick;
    logic [1:0] zx, waiting;
    logic [6:0] addr;
    logic [15:0] wdata, rdata;
    logic [5:0] lg, rg;
    logic ls, rs;
    int st[2], zc[2], cnt[2], appl[2], wt[2];
    int miscompares, tests_run, seed, i;
    hpvol_host i_hpvol_host (.CLK(clk), .WR_EN(wr_en), .ADDR(addr), .WDATA(wdata));
    hpvol_ctrl #(.TIMEOUT_TICKS(4'h3)) i_hpvol_ctrl (.CLK(clk), .RESET_N(reset_n),
        .WR_EN(wr_en), .ADDR(addr), .WDATA(wdata), .RDATA(rdata), .ZERO_CROSS(zx),
        .TIMEOUT_TICK(tick), .LEFT_APPLIED_GAIN(lg), .RIGHT_APPLIED_GAIN(rg),
        .LEFT_SILENCE_OUT(ls), .RIGHT_SILENCE_OUT(rs), .APPLY_WAITING(waiting));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic cmp();
        logic [15:0] e;
        // Packing is {waiting[1:0], right silence and gain, left silence and gain}
        e = 16'(wt[1]*32768 + wt[0]*16384 + appl[1]*128 + appl[0]);
        chk({waiting, rs, rg, ls, lg}, e);
    endtask
    task automatic w(input logic [6:0] a, input logic [15:0] d);
        int c;
        c = (a == HPVOL_ADDR_LEFT) ? 0 : (a == HPVOL_ADDR_RIGHT) ? 1 : 2;
        i_hpvol_host.wr(a, d);
        if (c < 2) begin
            if (!d[7]) cnt[c] = 0;
            else if (zc[c] != 0 && int'(d[6:0]) != st[c] && cnt[c] < 2) cnt[c]++;
            zc[c] = int'(d[7]);
            st[c] = int'(d[6:0]);
            for (int k = 0; k < 2 && d[8]; k++) begin
                if (cnt[k] >= 2) wt[k] = 1;
                else appl[k] = st[k];
            end
        end
        @(negedge clk);
        cmp();
        i_hpvol_host.rd(a);
        @(negedge clk);
        chk(rdata, (c < 2) ? 16'(zc[c]*128 + st[c]) : 16'h0000);
    endtask
    task automatic pulse(input int z);
        @(posedge clk);
        if (z != 0) zx <= 2'(z);
        else tick <= 1'b1;
        @(posedge clk);
        zx <= 2'h0;
        tick <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic conclude();
        $display("Counts: %0d compares, %0d mismatches", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #400000;
        miscompares++;
        conclude();
    end
    initial begin
        reset_n = 1'b0;
        tick = 1'b0;
        zx = 2'h0;
        seed = 72;
        for (i = 0; i < 2; i++) begin
            st[i] = 45;
            appl[i] = 45;
            zc[i] = 0;
            cnt[i] = 0;
            wt[i] = 0;
        end
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        cmp();
        w(HPVOL_ADDR_LEFT, 16'h0050);
        w(HPVOL_ADDR_RIGHT, 16'h017F);
        $display("Pending and commit test done");
        for (i = 0; i < 12; i++) begin
            w(7'h1C + 7'($unsigned($random(seed)) % 3), 16'($random(seed)) & 16'h017F);
        end
        $display("Random immediate test done");
        // arm left by stepping the gain down then up
        w(HPVOL_ADDR_LEFT, 16'h00AD);
        w(HPVOL_ADDR_LEFT, 16'h00AC);
        w(HPVOL_ADDR_LEFT, 16'h00AD);
        w(HPVOL_ADDR_LEFT, 16'h01A0);
        pulse(1);
        appl[0] = st[0];
        wt[0] = 0;
        cmp();
        w(HPVOL_ADDR_LEFT, 16'h01F0);
        for (i = 0; i < 2; i++) pulse(0);
        cmp();
        pulse(0);
        appl[0] = st[0];
        wt[0] = 0;
        cmp();
        $display("Zero-cross test done");
        // disarm left, arm right by toggling silence
        w(HPVOL_ADDR_LEFT, 16'h0070);
        w(HPVOL_ADDR_RIGHT, 16'h0095);
        w(HPVOL_ADDR_RIGHT, 16'h00D5);
        w(HPVOL_ADDR_RIGHT, 16'h0095);
        w(HPVOL_ADDR_RIGHT, 16'h0196);
        pulse(2);
        appl[1] = st[1];
        wt[1] = 0;
        cmp();
        $display("Silence arming test done");
        conclude();
    end
endmodule // tb_top
